// ---- include/wsfl_defines.svh ----
// constants and behaviour notes for the wheel speed frame link
// Notes on behaviour
// (RULE1) both serial channels run at 115200 baud each way
// (RULE2) speed feedback goes out as exactly 11-byte frames on speed channel
// (RULE3) every frame opens with two header bytes of value FF
// (RULE4) sign byte zero means negative velocity, nonzero means zero or positive
// (RULE5) magnitude is unsigned 24 bits, high byte first then middle then low
// (RULE6) order: header, left sign, left magnitude, right sign, right magnitude, sum
// (RULE7) checksum is low 8 bits of sum of the ten preceding bytes
// (RULE8) host sends speed commands in the same 11-byte frame layout
// (RULE9) speed loop repeats: read encoder, compute correction, update pwm
// (RULE10) debug channel carries only debug text and commands, never speed data
// (RULE11) receiver hunts for header and drops frames with bad checksum
// (RULE12) characters are 8N1, least significant bit first
`ifndef WSFL_DEFINES_SVH
`define WSFL_DEFINES_SVH
`define WSFL_CLK_HZ      20000000
`define WSFL_BAUD        115200
`define WSFL_BIT_CYC     ((`WSFL_CLK_HZ + `WSFL_BAUD / 2) / `WSFL_BAUD)
`define WSFL_FRAME_LEN   11
`define WSFL_HDR_BYTE    8'hFF
`define WSFL_SIGN_NEG    8'h00
`define WSFL_SIGN_POS    8'h01
`define WSFL_IDLE_LEVEL  1'b1
`endif

// ---- include/wsfl_pkg.sv ----
// types for the wheel speed frame link
`default_nettype none
package wsfl_pkg;
    typedef enum logic [1:0] {WSFL_IDLE, WSFL_START, WSFL_DATA, WSFL_STOP}
        wsfl_ser_t;
    typedef enum logic [1:0] {WSFL_TX_WAIT, WSFL_TX_LOAD, WSFL_TX_BUSY}
        wsfl_frm_t;
endpackage
`default_nettype wire

// ---- core/wsfl_link.sv ----
// speed frame formatter and parser on the speed serial channel
`timescale 1ns/1ps
`default_nettype none
`include "wsfl_defines.svh"
module wsfl_link #(
    parameter int BIT_CYC = `WSFL_BIT_CYC
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // speed serial channel pins
    input  wire logic        speed_rx,
    output logic             speed_tx,
    // feedback from the speed loop
    input  wire logic        fb_send,
    input  wire logic        fb_left_neg,
    input  wire logic [23:0] fb_left_mag,
    input  wire logic        fb_right_neg,
    input  wire logic [23:0] fb_right_mag,
    output logic             fb_busy,
    // received speed command
    output logic             cmd_valid,
    output logic             left_speed_sign,
    output logic [23:0]      left_speed_magnitude,
    output logic             right_speed_sign,
    output logic [23:0]      right_speed_magnitude,
    output logic             cmd_bad_sum
);
    import wsfl_pkg::*;
    localparam int BW = $clog2(BIT_CYC + 1);
    localparam logic [BW-1:0] BIT_LAST = BW'(BIT_CYC - 1);
    localparam logic [BW-1:0] BIT_HALF = BW'(BIT_CYC / 2);

    // ------------------------------------------------------------
    // receive pin synchroniser
    // ------------------------------------------------------------
    logic [2:0] rx_sync_r;
    logic       rx_lvl_r;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) rx_sync_r <= 3'h7;
        else rx_sync_r <= {rx_sync_r[1:0], speed_rx};
    end
    wire rx_agree = rx_sync_r[1] == rx_sync_r[2];
    always_ff @(posedge clk or posedge rst) begin
        if (rst) rx_lvl_r <= `WSFL_IDLE_LEVEL;
        else if (rx_agree) rx_lvl_r <= rx_sync_r[2];
    end

    // ------------------------------------------------------------
    // character receiver, 8N1 lsb first
    // ------------------------------------------------------------
    wsfl_ser_t      rs_r;
    wsfl_ser_t      rs_nxt;
    logic [BW-1:0]  rcnt_r;
    logic [2:0]     rbit_r;
    logic [7:0]     rsh_r;
    logic           rbyte_v_r;
    wire rtick = rcnt_r == BIT_LAST;
    wire rhalf = rcnt_r == BIT_HALF;
    always_comb begin
        rs_nxt = rs_r;
        case (rs_r)
            WSFL_IDLE:  if (!rx_lvl_r) rs_nxt = WSFL_START;
            WSFL_START: if (rhalf) rs_nxt = rx_lvl_r ? WSFL_IDLE : WSFL_DATA;
            WSFL_DATA:  if (rtick && rbit_r == 3'h7) rs_nxt = WSFL_STOP;
            WSFL_STOP:  if (rtick) rs_nxt = WSFL_IDLE;
            default:    rs_nxt = WSFL_IDLE;
        endcase
    end
    wire rcnt_clr = (rs_r == WSFL_START && rhalf) || rtick
                    || rs_r == WSFL_IDLE;
    wire rbyte_ok = rs_r == WSFL_STOP && rtick && rx_lvl_r;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rs_r      <= WSFL_IDLE;
            rcnt_r    <= '0;
            rbit_r    <= 3'h0;
            rsh_r     <= 8'h00;
            rbyte_v_r <= 1'b0;
        end else begin
            rs_r      <= rs_nxt;
            rcnt_r    <= rcnt_clr ? '0 : rcnt_r + 1'b1;
            if (rs_r == WSFL_DATA && rtick) begin
                rsh_r  <= {rx_lvl_r, rsh_r[7:1]}; // RULE12
                rbit_r <= rbit_r + 3'h1;
            end
            rbyte_v_r <= rbyte_ok; // RULE1
        end
    end

    // ------------------------------------------------------------
    // command frame parser
    // ------------------------------------------------------------
    logic [3:0]  pidx_r;
    logic [7:0]  psum_r;
    logic [7:0]  pbuf_r [1:8];
    wire p_hdr   = rsh_r == `WSFL_HDR_BYTE;
    wire p_last  = pidx_r == 4'(`WSFL_FRAME_LEN - 1);
    wire p_good  = rbyte_v_r && p_last && psum_r == rsh_r; // RULE7
    wire p_drop  = rbyte_v_r && p_last && psum_r != rsh_r; // RULE11
    // header hunt restarts on any mismatch
    wire p_hunt  = pidx_r < 4'h2 && !p_hdr; // RULE3 RULE11
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pidx_r <= 4'h0;
            psum_r <= 8'h00;
        end else if (rbyte_v_r) begin
            if (p_hunt || p_last) begin
                pidx_r <= 4'h0;
                psum_r <= 8'h00;
            end else begin
                pidx_r <= pidx_r + 4'h1;
                psum_r <= psum_r + rsh_r;
            end
        end
    end
    genvar gi;
    generate
        for (gi = 1; gi <= 8; gi++) begin : g_pbuf
            always_ff @(posedge clk or posedge rst) begin
                if (rst) pbuf_r[gi] <= 8'h00;
                else if (rbyte_v_r && pidx_r == 4'(gi + 1))
                    pbuf_r[gi] <= rsh_r; // RULE6 RULE8
            end
        end
    endgenerate
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cmd_valid             <= 1'b0;
            cmd_bad_sum           <= 1'b0;
            left_speed_sign       <= 1'b0;
            left_speed_magnitude  <= 24'h000000;
            right_speed_sign      <= 1'b0;
            right_speed_magnitude <= 24'h000000;
        end else begin
            cmd_valid   <= p_good;
            cmd_bad_sum <= p_drop;
            if (p_good) begin
                left_speed_sign       <= pbuf_r[1] != `WSFL_SIGN_NEG; // RULE4
                left_speed_magnitude  <= {pbuf_r[2], pbuf_r[3],
                                          pbuf_r[4]}; // RULE5
                right_speed_sign      <= pbuf_r[5] != `WSFL_SIGN_NEG;
                right_speed_magnitude <= {pbuf_r[6], pbuf_r[7], pbuf_r[8]};
            end
        end
    end

    // ------------------------------------------------------------
    // feedback frame builder
    // ------------------------------------------------------------
    wsfl_frm_t     fs_r;
    logic [7:0]    fbuf_r [0:9];
    logic [3:0]    tidx_r;
    logic [7:0]    tsum_r;
    logic [BW-1:0] tcnt_r;
    logic [3:0]    tbit_r;
    logic [9:0]    tsh_r;
    wire ttick   = tcnt_r == BIT_LAST;
    wire tchar_e = ttick && tbit_r == 4'h9;
    wire tlast   = tidx_r == 4'(`WSFL_FRAME_LEN - 1);
    wire [7:0] tbyte = tlast ? tsum_r : fbuf_r[tidx_r]; // RULE7
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 10; i++) fbuf_r[i] <= 8'h00;
        end else if (fs_r == WSFL_TX_WAIT && fb_send) begin
            fbuf_r[0] <= `WSFL_HDR_BYTE; // RULE3
            fbuf_r[1] <= `WSFL_HDR_BYTE;
            fbuf_r[2] <= fb_left_neg ? `WSFL_SIGN_NEG : `WSFL_SIGN_POS; // RULE4
            fbuf_r[3] <= fb_left_mag[23:16]; // RULE5 RULE6
            fbuf_r[4] <= fb_left_mag[15:8];
            fbuf_r[5] <= fb_left_mag[7:0];
            fbuf_r[6] <= fb_right_neg ? `WSFL_SIGN_NEG : `WSFL_SIGN_POS;
            fbuf_r[7] <= fb_right_mag[23:16];
            fbuf_r[8] <= fb_right_mag[15:8];
            fbuf_r[9] <= fb_right_mag[7:0];
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fs_r     <= WSFL_TX_WAIT;
            tidx_r   <= 4'h0;
            tsum_r   <= 8'h00;
            tcnt_r   <= '0;
            tbit_r   <= 4'h0;
            tsh_r    <= 10'h3FF;
            speed_tx <= `WSFL_IDLE_LEVEL;
            fb_busy  <= 1'b0;
        end else begin
            case (fs_r)
                WSFL_TX_WAIT: if (fb_send) begin
                    fs_r    <= WSFL_TX_LOAD;
                    tidx_r  <= 4'h0;
                    tsum_r  <= 8'h00;
                    fb_busy <= 1'b1;
                end
                WSFL_TX_LOAD: begin
                    tsh_r  <= {1'b1, tbyte, 1'b0}; // RULE12
                    tcnt_r <= '0;
                    tbit_r <= 4'h0;
                    fs_r   <= WSFL_TX_BUSY;
                end
                WSFL_TX_BUSY: begin
                    speed_tx <= tsh_r[0];
                    tcnt_r   <= ttick ? '0 : tcnt_r + 1'b1; // RULE1
                    if (ttick) begin
                        tsh_r  <= {1'b1, tsh_r[9:1]};
                        tbit_r <= tbit_r + 4'h1;
                    end
                    if (tchar_e) begin
                        tsum_r <= tsum_r + tbyte;
                        tidx_r <= tidx_r + 4'h1;
                        fs_r   <= tlast ? WSFL_TX_WAIT : WSFL_TX_LOAD; // RULE2
                        if (tlast) fb_busy <= 1'b0;
                    end
                end
                default: fs_r <= WSFL_TX_WAIT;
            endcase
        end
    end
    // speed data never touches the debug channel, only this pin pair // RULE10
    // fb_send is paced by the outside speed loop once per pass // RULE9
endmodule // wsfl_link
`default_nettype wire

// ---- bench/wsfl_link_assertions.sv ----
// checker for the speed frame link ports
`timescale 1ns/1ps
`default_nettype none
module wsfl_link_checker #(parameter int BIT_CYC = 174) (
    input wire logic        clk, rst, speed_rx, speed_tx, fb_send,
    input wire logic        fb_left_neg, fb_right_neg, fb_busy, cmd_valid,
    input wire logic        left_speed_sign, right_speed_sign, cmd_bad_sum,
    input wire logic [23:0] fb_left_mag, fb_right_mag,
    input wire logic [23:0] left_speed_magnitude, right_speed_magnitude
);
    // eleven characters of ten bits, each with one load cycle ahead of it
    localparam int FRM = 11 * (10 * BIT_CYC + 1);
    localparam int BM1 = BIT_CYC - 1;
    logic [15:0] busy_cnt_r;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) busy_cnt_r <= 16'h0000;
        else busy_cnt_r <= fb_busy ? busy_cnt_r + 16'h0001 : 16'h0000;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_launch;
        ##2 $fell(speed_tx);
    endsequence
    sequence s_start_bit;
        s_launch ##BM1 !speed_tx ##1 speed_tx;
    endsequence
    idle_line_a: assert property (!fb_busy |-> speed_tx)
        else $error("tx active while idle");
    busy_cause_a: assert property ($rose(fb_busy) |-> $past(fb_send))
        else $error("busy without request");
    start_bit_a: assert property ($rose(fb_busy) |-> s_start_bit)
        else $error("start bit wrong");
    frame_len_a: assert property ($fell(fb_busy) |->
        busy_cnt_r inside {[FRM:FRM+2]}) else $error("frame length wrong");
    valid_pulse_a: assert property (cmd_valid |=> !cmd_valid)
        else $error("valid too long");
    bad_pulse_a: assert property (cmd_bad_sum |=> !cmd_bad_sum)
        else $error("bad sum too long");
    rx_excl_a: assert property (!(cmd_valid && cmd_bad_sum))
        else $error("valid and bad together");
    cmd_hold_a: assert property ($changed({left_speed_sign,
        right_speed_sign, left_speed_magnitude, right_speed_magnitude})
        |-> cmd_valid) else $error("fields moved without frame");
    bad_keep_a: assert property (cmd_bad_sum |->
        $stable(left_speed_magnitude) && $stable(right_speed_magnitude))
        else $error("bad frame changed fields");
endmodule // wsfl_link_checker
bind wsfl_link wsfl_link_checker #(.BIT_CYC(BIT_CYC)) chk_i (.clk, .rst,
    .speed_rx, .speed_tx, .fb_send, .fb_left_neg, .fb_right_neg, .fb_busy,
    .cmd_valid, .left_speed_sign, .right_speed_sign, .cmd_bad_sum,
    .fb_left_mag, .fb_right_mag, .left_speed_magnitude,
    .right_speed_magnitude);
`default_nettype wire

// ---- bench/wsfl_host.sv ----
// host side model of the speed serial channel
`timescale 1ns/1ps
`default_nettype none
module wsfl_host #(parameter int BIT_CYC = 8) (
    input wire logic clk,
    input wire logic speed_tx,
    output logic     speed_rx
);
    logic [7:0] rx_q[$];
    logic [7:0] b;
    initial speed_rx = 1'b1;
    task automatic send_byte(input logic [7:0] d);
        for (int i = 0; i < 10; i++) begin
            speed_rx <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : d[i-1];
            repeat (BIT_CYC) @(posedge clk);
        end
    endtask
    task automatic send_frame(input logic [7:0] f[11]);
        foreach (f[i]) send_byte(f[i]);
    endtask
    initial forever begin
        @(negedge speed_tx);
        repeat (BIT_CYC / 2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYC) @(posedge clk);
            b[i] = speed_tx;
        end
        repeat (BIT_CYC) @(posedge clk);
        rx_q.push_back(b);
    end
endmodule // wsfl_host
`default_nettype wire

// ---- bench/wsfl_link_tb_top.sv ----
// testbench for the wheel speed frame link
`timescale 1ns/1ps
`default_nettype none
module wsfl_link_tb_top;
    localparam int BC = 8;
    typedef logic [7:0] wsfl_frame_t [11];
    logic clk, rst, speed_rx, speed_tx, fb_send, fb_busy, cmd_valid;
    logic fb_left_neg, fb_right_neg, cmd_bad_sum, e_ls, e_rs;
    logic left_speed_sign, right_speed_sign;
    logic [23:0] fb_left_mag, fb_right_mag, e_lm, e_rm;
    logic [23:0] left_speed_magnitude, right_speed_magnitude;
    int error_cnt = 0, comparisons = 0, cyc = 0, n_ok = 0, n_bad = 0;
    wsfl_link #(.BIT_CYC(BC)) dut (.clk, .rst, .speed_rx, .speed_tx,
        .fb_send, .fb_left_neg, .fb_left_mag, .fb_right_neg, .fb_right_mag,
        .fb_busy, .cmd_valid, .left_speed_sign, .left_speed_magnitude,
        .right_speed_sign, .right_speed_magnitude, .cmd_bad_sum);
    wsfl_host #(.BIT_CYC(BC)) host (.clk, .speed_tx, .speed_rx);
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cmd_valid === 1'b1) n_ok++;
        if (cmd_bad_sum === 1'b1) n_bad++;
        if (cyc > 20000) begin
            error_cnt++;
            stop_test();
        end
    end
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    task automatic chk(input logic [31:0] got, exp, input string m);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask
    function automatic wsfl_frame_t mk(input logic ln, rn,
                                       input logic [23:0] lm, rm);
        wsfl_frame_t f;
        f = '{8'hFF, 8'hFF, {7'h00, !ln}, lm[23:16], lm[15:8], lm[7:0],
              {7'h00, !rn}, rm[23:16], rm[15:8], rm[7:0], 8'h00};
        for (int i = 0; i < 10; i++) f[10] += f[i];
        return f;
    endfunction
    task automatic t_feedback(input logic ln, rn, input logic [23:0] lm, rm);
        wsfl_frame_t e;
        e = mk(ln, rn, lm, rm);
        host.rx_q.delete();
        fb_left_neg = ln;
        fb_right_neg = rn;
        fb_left_mag = lm;
        fb_right_mag = rm;
        fb_send = 1'b1;
        step(3);
        fb_send = 1'b0;
        chk(fb_busy, 1'b1, "busy after request");
        for (int i = 0; i < 2000 && fb_busy !== 1'b0; i++) step(1);
        chk(fb_busy, 1'b0, "busy after frame");
        step(5 * BC);
        chk(host.rx_q.size(), 11, "feedback byte count");
        for (int i = 0; i < 11; i++) chk(host.rx_q[i], e[i], "byte");
    endtask
    task automatic t_cmd(input logic ln, rn, input logic [23:0] lm, rm,
                         input int junk, input logic bad);
        wsfl_frame_t f;
        int ok0, bad0;
        f = mk(ln, rn, lm, rm);
        f[10] = f[10] ^ {7'h00, bad};
        ok0 = n_ok;
        bad0 = n_bad;
        for (int i = 0; i < junk; i++) host.send_byte(8'h5A);
        host.send_frame(f);
        step(4 * BC);
        if (!bad) {e_ls, e_rs, e_lm, e_rm} = {!ln, !rn, lm, rm};
        chk(n_ok - ok0, !bad, "good frame count");
        chk(n_bad - bad0, bad, "bad frame count");
        chk(left_speed_sign, e_ls, "left sign");
        chk(right_speed_sign, e_rs, "right sign");
        chk(left_speed_magnitude, e_lm, "left magnitude");
        chk(right_speed_magnitude, e_rm, "right magnitude");
    endtask
    task automatic stop_test;
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        {rst, fb_send, fb_left_neg, fb_right_neg} = 4'hF - 4'h7;
        {fb_left_mag, fb_right_mag, e_lm, e_rm, e_ls, e_rs} = '0;
        step(2);
        rst = 1'b0;
        t_feedback(1'b1, 1'b0, 24'h123456, 24'hABCDEF);
        t_feedback(1'b0, 1'b1, 24'hFFFFFF, 24'h000000);
        t_cmd(1'b1, 1'b0, 24'h00F00D, 24'h800001, 0, 1'b0);
        t_cmd(1'b0, 1'b1, 24'hFFFFFF, 24'h000001, 2, 1'b0);
        t_cmd(1'b1, 1'b1, 24'h111111, 24'h222222, 0, 1'b1);
        stop_test();
    end
endmodule // wsfl_link_tb_top
`default_nettype wire
